// ### map_decode_pkg.sv
package map_decode_pkg;
  // Core address map
  localparam logic [15:0] WINDOW_BASE = 16'h8000;
  localparam logic [15:0] WINDOW_LAST = 16'hbfff;
  localparam logic [15:0] UNPAGED_BASE = 16'hc000;
  localparam logic [1:0] BLOCK_LOW = 2'h0;
  localparam logic [1:0] BLOCK_MID = 2'h1;
  localparam logic [1:0] BLOCK_WIN = 2'h2;
  localparam logic [1:0] BLOCK_TOP = 2'h3;
  // Extended address constants outside the window
  localparam logic [5:0] XADDR_LOW = 6'h3d;
  localparam logic [5:0] XADDR_MID = 6'h3e;
  localparam logic [5:0] XADDR_TOP = 6'h3f;
  // On-chip page thresholds per partition setting
  localparam logic [5:0] ONCHIP_FIRST_00 = 6'h38;
  localparam logic [5:0] ONCHIP_FIRST_01 = 6'h30;
  localparam logic [5:0] ONCHIP_FIRST_10 = 6'h20;
  localparam logic [5:0] ONCHIP_FIRST_11 = 6'h00;
  // Page register reset value
  localparam logic [5:0] PAGE_RESET = 6'h00;
  // Register block offsets for bus-expansion registers (relative to register base)
  localparam logic [15:0] OFS_PORT_A_DATA = 16'h0000;
  localparam logic [15:0] OFS_PORT_B_DATA = 16'h0001;
  localparam logic [15:0] OFS_PORT_A_DIR = 16'h0002;
  localparam logic [15:0] OFS_PORT_B_DIR = 16'h0003;
  localparam logic [15:0] OFS_PORT_E_DATA = 16'h0008;
  localparam logic [15:0] OFS_PORT_E_DIR = 16'h0009;
  localparam logic [15:0] OFS_EXP_COUNT = 16'h0010;
  localparam logic [15:0] OFS_PORT_K_DATA = 16'h0032;
  localparam logic [15:0] OFS_PORT_K_DIR = 16'h0033;
  // Operating modes
  typedef enum logic [2:0] {
    MODE_SPECIAL_SINGLE = 3'b000,
    MODE_EMUL_NARROW = 3'b001,
    MODE_SPECIAL_TEST = 3'b010,
    MODE_EMUL_WIDE = 3'b011,
    MODE_NORMAL_SINGLE = 3'b100,
    MODE_NORMAL_NARROW = 3'b101,
    MODE_SPECIAL_PERIPH = 3'b110,
    MODE_NORMAL_WIDE = 3'b111
  } op_mode_t;
  // Paged call/return sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_PUSH_RET = 3'b001,
    SEQ_PUSH_PAGE = 3'b010,
    SEQ_PULL_PAGE = 3'b011,
    SEQ_PULL_RET = 3'b100,
    SEQ_WRITE_PAGE = 3'b101,
    SEQ_REFILL = 3'b110
  } seq_state_t;
endpackage

// ### read_mux.sv
`timescale 1ns/1ps
`default_nettype none
module read_mux (
  // Source buses
  input wire logic [15:0] regs_rdata_in,
  input wire logic [15:0] ram_rdata_in,
  input wire logic [15:0] eeprom_rdata_in,
  input wire logic [15:0] flash_rdata_in,
  input wire logic [15:0] debug_rdata_in,
  input wire logic [15:0] ext_rdata_in,
  // Select and swap
  input wire logic [5:0] sel_in,
  input wire logic swap_in,
  // CPU side
  output logic [15:0] rdata_out
);
  logic [15:0] picked;
  // One-hot selects, so an OR of gated sources suffices
  assign picked = ({16{sel_in[0]}} & debug_rdata_in) | ({16{sel_in[1]}} & regs_rdata_in)
    | ({16{sel_in[2]}} & ram_rdata_in) | ({16{sel_in[3]}} & eeprom_rdata_in)
    | ({16{sel_in[4]}} & flash_rdata_in) | ({16{sel_in[5]}} & ext_rdata_in);
  // Byte swap for odd-aligned reads
  assign rdata_out = swap_in ? {picked[7:0], picked[15:8]} : picked;
endmodule // read_mux
`default_nettype wire

// ### address_decode_and_paging.sv
`timescale 1ns/1ps
`default_nettype none
module address_decode_and_paging
  import map_decode_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  // Configuration
  input wire map_decode_pkg::op_mode_t mode_in,
  input wire logic port_e_emulation_enable_in,
  input wire logic port_k_emulation_enable_in,
  input wire logic [1:0] paging_partition_switches_in,
  input wire logic [1:0] flash_alloc_in,
  input wire logic flash_hidden_in,
  input wire logic page_write_special_only_in,
  // Region hits from mapping registers
  input wire logic debug_hit_in,
  input wire logic reg_hit_in,
  input wire logic reg_implemented_in,
  input wire logic [15:0] reg_base_in,
  input wire logic ram_hit_in,
  input wire logic eeprom_hit_in,
  input wire logic flash_hit_in,
  // CPU bus
  input wire logic [15:0] cpu_addr_in,
  input wire logic [15:0] cpu_wdata_in,
  input wire logic cpu_valid_in,
  input wire logic cpu_swap_in,
  input wire logic page_wr_in,
  input wire logic [5:0] page_wdata_in,
  // Paged call/return control
  input wire logic call_start_in,
  input wire logic call_indirect_in,
  input wire logic [5:0] call_imm_page_in,
  input wire logic [5:0] call_mem_page_in,
  input wire logic rtc_start_in,
  input wire logic [5:0] stack_page_in,
  input wire logic step_ack_in,
  // Read data sources
  input wire logic [15:0] regs_rdata_in,
  input wire logic [15:0] ram_rdata_in,
  input wire logic [15:0] eeprom_rdata_in,
  input wire logic [15:0] flash_rdata_in,
  input wire logic [15:0] debug_rdata_in,
  input wire logic [15:0] ext_rdata_in,
  // Selects and CPU side outputs
  output logic [5:0] select_out,
  output logic [15:0] cpu_rdata_out,
  output logic [15:0] core_addr_out,
  output logic [15:0] core_wdata_out,
  // Page register and sequencer
  output logic [5:0] page_index_out,
  output logic [5:0] saved_page_out,
  output logic irq_hold_out,
  output logic push_ret_out,
  output logic push_page_out,
  output logic pull_page_out,
  output logic pull_ret_out,
  output logic refill_out,
  output logic page_fetch_indirect_out,
  // Port K pins
  output logic emulation_chip_select_n_out,
  output logic external_chip_select_n_out,
  output logic chip_selects_active_out,
  output logic [5:0] extended_address_out
);
  import map_decode_pkg::*;

  // Offset of current address in register block
  function automatic logic [15:0] reg_offset(input logic [15:0] a, input logic [15:0] b);
    reg_offset = a - b;
  endfunction

  // Mode classes
  wire logic expanded = mode_in == MODE_EMUL_NARROW || mode_in == MODE_EMUL_WIDE
    || mode_in == MODE_SPECIAL_TEST || mode_in == MODE_NORMAL_NARROW
    || mode_in == MODE_NORMAL_WIDE;
  wire logic emulation = mode_in == MODE_EMUL_NARROW || mode_in == MODE_EMUL_WIDE;
  wire logic periph = mode_in == MODE_SPECIAL_PERIPH;
  wire logic special = ~mode_in[2];

  // Register removal decode
  // Offsets count from the register base, so a moved block still decodes
  wire logic [15:0] ofs = reg_offset(cpu_addr_in, reg_base_in);
  wire logic is_port_ab = ofs == OFS_PORT_A_DATA || ofs == OFS_PORT_B_DATA
    || ofs == OFS_PORT_A_DIR || ofs == OFS_PORT_B_DIR;
  wire logic is_port_e = ofs == OFS_PORT_E_DATA || ofs == OFS_PORT_E_DIR;
  wire logic is_port_k = ofs == OFS_PORT_K_DATA || ofs == OFS_PORT_K_DIR;
  wire logic rm_ab = expanded && is_port_ab;
  wire logic rm_e = expanded && port_e_emulation_enable_in && is_port_e;
  wire logic rm_first16 = periph && ofs < OFS_EXP_COUNT;
  wire logic rm_k = emulation && port_k_emulation_enable_in && is_port_k;
  wire logic removed = reg_hit_in && (rm_ab || rm_e || rm_first16 || rm_k);
  wire logic reg_live = reg_hit_in && !removed;

  // Page window and partition
  logic [5:0] page_q, page_d;
  logic [5:0] saved_q;
  logic [5:0] onchip_first;
  wire logic [1:0] block = cpu_addr_in[15:14];
  wire logic in_window = block == BLOCK_WIN;
  // Partition threshold lookup
  always_comb begin
    case (paging_partition_switches_in)
      2'h0: onchip_first = ONCHIP_FIRST_00;
      2'h1: onchip_first = ONCHIP_FIRST_01;
      2'h2: onchip_first = ONCHIP_FIRST_10;
      default: onchip_first = ONCHIP_FIRST_11;
    endcase
  end
  wire logic window_internal = page_q >= onchip_first;
  // An off-chip window page falls through the flash select to external space in an expanded mode
  wire logic flash_live = flash_hit_in && (!in_window || window_internal);

  // Priority chain, combinational from current address
  wire logic s_dbg = debug_hit_in;
  wire logic s_reg = !s_dbg && reg_live;
  wire logic s_ram = !s_dbg && !reg_hit_in && ram_hit_in;
  wire logic s_eep = !s_dbg && !reg_hit_in && !ram_hit_in && eeprom_hit_in;
  wire logic s_fl = !s_dbg && !reg_hit_in && !ram_hit_in && !eeprom_hit_in && flash_live;
  wire logic claimed = s_dbg || reg_hit_in || ram_hit_in || eeprom_hit_in || flash_live;
  // Removed registers still go external; unimplemented register holes do not
  // Peripheral mode has no expanded bus, yet its removed registers still go out
  wire logic s_ext = (expanded && !claimed) || (removed && !s_dbg);
  assign select_out = cpu_valid_in ? {s_ext, s_fl, s_eep, s_ram, s_reg, s_dbg} : 6'h00;

  // Emulation chip select per allocation and hide bit
  // Hidden low blocks only matter with 48K or 64K allocated
  logic ecs_hit;
  always_comb begin
    case (block)
      BLOCK_LOW: ecs_hit = flash_alloc_in == 2'h3 && !flash_hidden_in;
      BLOCK_MID: ecs_hit = flash_alloc_in[1] && !flash_hidden_in;
      BLOCK_WIN: ecs_hit = flash_alloc_in == 2'h0 || (flash_alloc_in[1] && window_internal);
      default: ecs_hit = 1'b1;
    endcase
  end
  // Pins carry selects only in an expanded mode with the port K enable set
  wire logic pins_on = port_k_emulation_enable_in && expanded;
  wire logic ecs_act = pins_on && emulation && cpu_valid_in && ecs_hit && !s_dbg && !reg_hit_in;
  // Removed registers and holes are kept off the external select
  wire logic xcs_act = pins_on && cpu_valid_in && !ecs_act && s_ext && !removed
    && !(reg_hit_in && !reg_implemented_in);
  assign emulation_chip_select_n_out = !ecs_act;
  assign external_chip_select_n_out = !xcs_act;
  assign chip_selects_active_out = port_k_emulation_enable_in;

  // Extended address: page in window, constants elsewhere
  always_comb begin
    case (block)
      BLOCK_LOW: extended_address_out = XADDR_LOW;
      BLOCK_MID: extended_address_out = XADDR_MID;
      BLOCK_WIN: extended_address_out = page_q;
      default: extended_address_out = XADDR_TOP;
    endcase
  end

  // Bus steering and read mux
  assign core_addr_out = cpu_addr_in;
  assign core_wdata_out = cpu_wdata_in;
  read_mux u_read_mux (
    .regs_rdata_in(regs_rdata_in),
    .ram_rdata_in(ram_rdata_in),
    .eeprom_rdata_in(eeprom_rdata_in),
    .flash_rdata_in(flash_rdata_in),
    .debug_rdata_in(debug_rdata_in),
    .ext_rdata_in(ext_rdata_in),
    .sel_in(select_out),
    .swap_in(cpu_swap_in),
    .rdata_out(cpu_rdata_out)
  );

  // Paged call/return sequencer
  seq_state_t st_q, st_d;
  // Restricted integrations take plain page writes only in modes with mode bit 2 clear, including both emulation modes but not special peripheral
  wire logic wr_allowed = !page_write_special_only_in || special;
  wire logic [5:0] new_page = call_indirect_in ? call_mem_page_in : call_imm_page_in;
  wire logic idle = st_q == SEQ_IDLE;
  always_comb begin
    st_d = st_q;
    page_d = page_q;
    case (st_q)
      SEQ_IDLE: begin
        if (call_start_in) begin
          page_d = new_page;
          st_d = SEQ_PUSH_RET;
        end else if (rtc_start_in) begin
          st_d = SEQ_PULL_PAGE;
        end else if (page_wr_in && wr_allowed) begin
          page_d = page_wdata_in;
        end
      end
      SEQ_PUSH_RET: if (step_ack_in) st_d = SEQ_PUSH_PAGE;
      SEQ_PUSH_PAGE: if (step_ack_in) st_d = SEQ_REFILL;
      SEQ_PULL_PAGE: if (step_ack_in) st_d = SEQ_PULL_RET;
      SEQ_PULL_RET: if (step_ack_in) st_d = SEQ_WRITE_PAGE;
      SEQ_WRITE_PAGE: begin
        page_d = saved_q;
        st_d = SEQ_REFILL;
      end
      SEQ_REFILL: if (step_ack_in) st_d = SEQ_IDLE;
      default: st_d = SEQ_IDLE;
    endcase
  end

  // State, page and temporary registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= SEQ_IDLE;
      page_q <= PAGE_RESET;
      saved_q <= PAGE_RESET;
    end else if (clk_en_in) begin
      st_q <= st_d;
      page_q <= page_d;
      // Temporary page: old page on a call, stacked page on a return
      if (idle && call_start_in) saved_q <= page_q;
      else if (st_q == SEQ_PULL_PAGE && step_ack_in) saved_q <= stack_page_in;
    end
  end

  // Step flags decode the state register, so they never glitch
  assign page_index_out = page_q;
  assign saved_page_out = saved_q;
  assign irq_hold_out = !idle;
  assign push_ret_out = st_q == SEQ_PUSH_RET;
  assign push_page_out = st_q == SEQ_PUSH_PAGE;
  assign pull_page_out = st_q == SEQ_PULL_PAGE;
  assign pull_ret_out = st_q == SEQ_PULL_RET;
  assign refill_out = st_q == SEQ_REFILL;
  assign page_fetch_indirect_out = idle && call_start_in && call_indirect_in;

  // Decode checks: one select at a time, in priority order
  chk_one_select: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $onehot0(select_out))
    else $error("more than one select active");
  chk_idle_no_select: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !cpu_valid_in |-> select_out == 6'h00)
    else $error("select without a valid access");
  chk_debug_first: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (cpu_valid_in && debug_hit_in) |-> select_out == 6'h01)
    else $error("debug space did not win");
  chk_reg_over_ram: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (cpu_valid_in && reg_hit_in && !removed && !debug_hit_in) |-> select_out[1] && !select_out[2])
    else $error("register did not win over ram");
  chk_ram_over_eeprom: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (cpu_valid_in && ram_hit_in && !reg_hit_in && !debug_hit_in) |-> select_out == 6'h04)
    else $error("ram did not win over lower blocks");
  chk_removed_ext: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (cpu_valid_in && removed && !debug_hit_in) |-> select_out == 6'h20)
    else $error("removed register not decoded external");
  chk_window_external: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (cpu_valid_in && in_window && !window_internal) |-> !select_out[4])
    else $error("off-chip window page selected flash");
  chk_full_onchip: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    paging_partition_switches_in == 2'h3 |-> window_internal)
    else $error("full on-chip split left a page external");

  // Chip select, extended address and byte swap checks; both pins idle high unless the port K enable is set
  chk_selects_exclusive: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !(emulation_chip_select_n_out == 1'b0 && external_chip_select_n_out == 1'b0))
    else $error("both chip selects active");
  chk_pins_off: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !port_k_emulation_enable_in |-> emulation_chip_select_n_out && external_chip_select_n_out)
    else $error("chip select with enable clear");
  chk_ecs_emul_only: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !emulation |-> emulation_chip_select_n_out)
    else $error("emulation select outside emulation mode");
  chk_xcs_needs_ext: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !external_chip_select_n_out |-> select_out[5])
    else $error("external select without external space");
  chk_xcs_off_single: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !expanded |-> external_chip_select_n_out)
    else $error("external select in a single-chip mode");
  chk_no_xcs_removed: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    removed |-> external_chip_select_n_out)
    else $error("external select on removed register");
  chk_unimpl_no_xcs: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (reg_hit_in && !reg_implemented_in) |-> external_chip_select_n_out)
    else $error("external select on register hole");
  chk_xaddr_page: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    in_window |-> extended_address_out == page_q)
    else $error("window page not on extended address");
  chk_swap_bytes: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (cpu_swap_in && select_out == 6'h01) |-> cpu_rdata_out == {debug_rdata_in[7:0], debug_rdata_in[15:8]})
    else $error("read bytes not swapped");

  // Page register and call/return sequencer checks
  chk_write_delay: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (clk_en_in && idle && !call_start_in && !rtc_start_in && page_wr_in && wr_allowed)
    |=> page_q == $past(page_wdata_in))
    else $error("page write not applied next cycle");
  chk_write_refused: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (clk_en_in && idle && !call_start_in && !rtc_start_in && page_wr_in && !wr_allowed)
    |=> page_q == $past(page_q))
    else $error("restricted page write applied");
  chk_enable_freeze: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !clk_en_in |=> st_q == $past(st_q) && page_q == $past(page_q) && saved_q == $past(saved_q))
    else $error("state moved with clock enable low");
  chk_call_saves: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (clk_en_in && idle && call_start_in) |=> saved_q == $past(page_q) && st_q == SEQ_PUSH_RET)
    else $error("call did not save page");
  chk_call_loads: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (clk_en_in && idle && call_start_in) |=> page_q == $past(new_page))
    else $error("call did not load new page");
  chk_call_steps: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (clk_en_in && st_q == SEQ_PUSH_RET && step_ack_in) |=> st_q == SEQ_PUSH_PAGE)
    else $error("return address push did not lead to page push");
  chk_push_refill: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (clk_en_in && st_q == SEQ_PUSH_PAGE && step_ack_in) |=> st_q == SEQ_REFILL)
    else $error("page push did not lead to refill");
  chk_irq_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (clk_en_in && idle && (call_start_in || rtc_start_in)) |=> irq_hold_out)
    else $error("interrupts not held during sequence");
  chk_ret_pulls: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (clk_en_in && st_q == SEQ_PULL_PAGE && step_ack_in) |=> saved_q == $past(stack_page_in))
    else $error("return did not take stacked page");
  chk_ret_writes: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (clk_en_in && st_q == SEQ_WRITE_PAGE) |=> page_q == $past(saved_q) && refill_out)
    else $error("return did not write page before refill");
endmodule // address_decode_and_paging
`default_nettype wire

// ### mem_side_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stack and memory side facing the core bus
module mem_side_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Sequencer handshake
  input wire logic irq_hold_in,
  output logic step_ack_out,
  // Read buses in select order
  output logic [15:0] rdata_out [6]
);
  int wait_q;
  int seed_q = 5;
  // Unequal halves so a missed byte swap shows
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      rdata_out[i] = {4'h9, i[3:0], 8'h3c ^ i[7:0]};
    end
  end
  // Acks each step after 1 to 3 cycles, so both prompt and slow answers occur
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      step_ack_out <= 1'b0;
      wait_q <= 0;
    end else if (irq_hold_in && !step_ack_out && wait_q == 0) begin
      step_ack_out <= 1'b1;
      wait_q <= $random(seed_q) & 3;
    end else begin
      step_ack_out <= 1'b0;
      if (wait_q > 0) begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule // mem_side_model
`default_nettype wire

// ### address_decode_and_paging_tb.sv
`timescale 1ns/1ps
`default_nettype none
module address_decode_and_paging_tb;
  import map_decode_pkg::*;
  logic clk_in = 0;
  logic rst_b_in = 0;
  logic pe = 0, pk = 0, hid = 0, wso = 0, dh = 0, rh = 0, rimp = 0, ramh = 0, eeh = 0, flh = 0;
  logic vld = 0, swp = 0, pwr = 0, cst = 0, cind = 0, rtc = 0, ce = 1;
  logic [1:0] psw = 0, alloc = 0;
  logic [15:0] addr = 0, wd = 0, rb = 0;
  logic [5:0] pwd = 0, cimm = 0, cmem = 0, spg = 0, mpg = 0;
  op_mode_t mode = MODE_NORMAL_WIDE;
  logic [5:0] sel, pg, svd, xa;
  logic [15:0] rdata, caddr, cwd;
  logic hold, pr, pp, pl, plr, rf, pfi, ecs_n, xcs_n, csa, ack;
  logic [15:0] bus [6];
  logic [4:0] q [$];
  logic [5:0] pgs [4] = '{6'h1f, 6'h20, 6'h37, 6'h38};
  int err_total = 0, compares = 0, seed = 92767;

  address_decode_and_paging uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(ce), .mode_in(mode),
    .port_e_emulation_enable_in(pe), .port_k_emulation_enable_in(pk), .paging_partition_switches_in(psw),
    .flash_alloc_in(alloc), .flash_hidden_in(hid), .page_write_special_only_in(wso), .debug_hit_in(dh),
    .reg_hit_in(rh), .reg_implemented_in(rimp), .reg_base_in(rb), .ram_hit_in(ramh), .eeprom_hit_in(eeh),
    .flash_hit_in(flh), .cpu_addr_in(addr), .cpu_wdata_in(wd), .cpu_valid_in(vld), .cpu_swap_in(swp),
    .page_wr_in(pwr), .page_wdata_in(pwd), .call_start_in(cst), .call_indirect_in(cind),
    .call_imm_page_in(cimm), .call_mem_page_in(cmem), .rtc_start_in(rtc), .stack_page_in(spg),
    .step_ack_in(ack), .regs_rdata_in(bus[1]), .ram_rdata_in(bus[2]), .eeprom_rdata_in(bus[3]),
    .flash_rdata_in(bus[4]), .debug_rdata_in(bus[0]), .ext_rdata_in(bus[5]), .select_out(sel),
    .cpu_rdata_out(rdata), .core_addr_out(caddr), .core_wdata_out(cwd), .page_index_out(pg),
    .saved_page_out(svd), .irq_hold_out(hold), .push_ret_out(pr), .push_page_out(pp), .pull_page_out(pl),
    .pull_ret_out(plr), .refill_out(rf), .page_fetch_indirect_out(pfi), .emulation_chip_select_n_out(ecs_n),
    .external_chip_select_n_out(xcs_n), .chip_selects_active_out(csa), .extended_address_out(xa));
  mem_side_model partner (.clk_in(clk_in), .rst_b_in(rst_b_in), .irq_hold_in(hold), .step_ack_out(ack),
    .rdata_out(bus));

  // Free-running 100 MHz clock
  initial begin
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Plain page write; refused silently in normal and special peripheral modes when restricted
  task automatic pw(input logic [5:0] d);
    @(posedge clk_in) #1;
    pwr = 1;
    pwd = d;
    #3 chk(pg, mpg);
    @(posedge clk_in) #1;
    pwr = 0;
    if (!wso || !mode[2]) mpg = d;
    chk(pg, mpg);
  endtask

  // Records the distinct step flags until the sequence drops its hold
  task automatic walk(input logic [14:0] ex);
    logic [4:0] c;
    q = {};
    for (int i = 0; i < 60 && hold !== 1'b0; i++) begin
      c = {pr, pp, pl, plr, rf};
      if (c != 0) chk(hold, 1);
      if (c != 0 && (q.size() == 0 || q[$] != c)) q.push_back(c);
      @(posedge clk_in) #1;
    end
    chk(hold, 16'h0000);
    chk(16'(q.size()), 3);
    for (int i = 0; i < 3 && i < q.size(); i++) chk(q[i], ex[14-5*i -: 5]);
  endtask

  task automatic call(input logic ind, input logic [5:0] p);
    @(posedge clk_in) #1;
    cst = 1;
    cind = ind;
    cimm = p;
    cmem = ~p;
    #3 chk(pfi, ind);
    @(posedge clk_in) #1;
    cst = 0;
    chk(svd, mpg);
    mpg = ind ? ~p : p;
    chk(pg, mpg);
    walk({5'b10000, 5'b01000, 5'b00001});
  endtask

  task automatic ret(input logic [5:0] s);
    @(posedge clk_in) #1;
    rtc = 1;
    spg = s;
    @(posedge clk_in) #1;
    rtc = 0;
    walk({5'b00100, 5'b00010, 5'b00001});
    mpg = s;
    chk(pg, mpg);
  endtask

  // One random access against the priority and chip-select model
  task automatic dec();
    logic expd, emul, rm, emulation_chip_select_n, inr;
    logic [5:0] e, thr;
    logic [15:0] s, ofs;
    @(posedge clk_in) #1;
    mode = op_mode_t'(3'($random(seed)));
    {pe, pk, hid, swp, rimp, psw, alloc} = 9'($random(seed));
    {dh, rh, ramh, eeh, flh} = 5'($random(seed) & $random(seed));
    vld = ($random(seed) & 3) != 0;
    addr = 16'($random(seed));
    rb = {5'($random(seed)), 11'h000};
    if (addr[0]) addr = rb + {10'h000, addr[6:1]};
    wd = 16'($random(seed));
    #3;
    expd = !(mode inside {MODE_NORMAL_SINGLE, MODE_SPECIAL_SINGLE, MODE_SPECIAL_PERIPH});
    emul = mode inside {MODE_EMUL_NARROW, MODE_EMUL_WIDE};
    ofs = addr - rb;
    rm = rh && (expd && (ofs < 4 || pe && ofs inside {8, 9}) || mode == MODE_SPECIAL_PERIPH && ofs < 16
      || emul && pk && ofs inside {16'h32, 16'h33});
    thr = psw == 0 ? 6'h38 : psw == 1 ? 6'h30 : psw == 2 ? 6'h20 : 6'h00;
    inr = mpg >= thr;
    // An off-chip window page is not flash, so in an expanded mode it falls to external space
    e = !vld ? 0 : dh ? 1 : rm ? 32 : rh ? 2 : ramh ? 4 : eeh ? 8 : flh && (addr[15:14] != 2 || inr) ? 16
      : expd ? 32 : 0;
    chk(sel, e);
    chk(caddr, addr);
    chk(cwd, wd);
    s = 0;
    for (int i = 0; i < 6; i++) if (e[i]) s = bus[i];
    if (e != 0) chk(rdata, swp ? {s[7:0], s[15:8]} : s);
    chk(csa, pk);
    case (addr[15:14])
      2'd0: emulation_chip_select_n = alloc == 3 && !hid;
      2'd1: emulation_chip_select_n = alloc > 1 && !hid;
      2'd2: emulation_chip_select_n = alloc == 0 || alloc > 1 && inr;
      default: emulation_chip_select_n = 1;
    endcase
    emulation_chip_select_n = emulation_chip_select_n && emul && !dh && !rh; // Debug and register hits are not program space
    if (pk && vld) chk(ecs_n, !emulation_chip_select_n);
    if (pk && vld) chk(xcs_n, !(e == 32 && !rm && !emulation_chip_select_n));
    if (pk && vld && expd) chk(xa, addr[15:14] == 2 ? mpg : 6'h3d + (addr[15] ? 6'h2 : 6'(addr[14])));
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_in);
    #1 rst_b_in = 1;
    chk(pg, 6'h00);
    for (int k = 0; k < 4; k++) begin
      wso = 0;
      pw(pgs[k]);
      repeat (100) dec();
    end
    // Enable low must hold the page through a write strobe
    @(posedge clk_in) #1;
    ce = 0;
    pwr = 1;
    pwd = ~mpg;
    @(posedge clk_in) #1;
    chk(pg, mpg);
    ce = 1;
    pwr = 0;
    for (int k = 0; k < 16; k++) begin
      mode = op_mode_t'(k[2:0]);
      wso = k[3];
      pw(6'($random(seed)));
    end
    call(0, 6'h2a);
    call(1, 6'h15);
    ret(6'h3c);
    ret(6'h07);
    test_done();
  end

  // Cuts a hang short well beyond the expected few hundred cycles
  initial begin
    #100us;
    err_total++;
    test_done();
  end
endmodule // address_decode_and_paging_tb
`default_nettype wire
